//--- hw/position_error_clear_and_gear.v
// The implementer's own choices: the register offsets and the Wishbone slave port.
`timescale 1ns/1ns
`include "gear_defines.vh"
// Gear scaling and position error counter with clear logic.
// Each reference pulse adds num/den encoder counts; remainder is carried.
//
// Timing, in core clock cycles:
//   Bus: a request is taken on an edge with ack low; ack and read data
//   follow one cycle later and stand for one cycle. A write lands on the
//   edge at which the master samples ack high, with the request standing.
//   Reference pin: two synchroniser flops and an edge detector, so the
//   error counter moves three edges after the pin rises.
//   Clear pin: same two flops; the counter reads zero three edges after
//   the pin falls and the loop enable drops with it.
//   Feedback and overtravel come from logic on this clock and are used
//   as they arrive, with no added delay.
// Sign convention: a forward reference adds to the error and a forward
// encoder count takes away, so a settled axis holds the error at zero.
// Limitation: a reference pulse must stay high and low for two cycles or
// more, otherwise the synchroniser may merge two pulses into one.
// Trade-off: the gear division is done in one cycle, which costs area but
// keeps the count exact with no pipeline to drain at a clear.
module position_error_clear_and_gear #(
  parameter ERR_W = 32,
  parameter ENC_LINES = 32768
) (
  // Clock and reset
  input wire i_core_clk,
  input wire i_rst,
  // Wishbone slave
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_wb_we,
  input wire [7:0] i_wb_adr,
  input wire [3:0] i_wb_sel,
  input wire [31:0] i_wb_dat,
  output reg [31:0] o_wb_dat,
  output reg o_wb_ack,
  // Host pins (asynchronous)
  input wire i_ref_pulse,
  input wire i_ref_dir,
  input wire i_error_clear_n,
  // Drive status (same clock)
  input wire i_overtravel,
  input wire i_fb_pulse,
  input wire i_fb_dir,
  // Outputs
  output reg [ERR_W-1:0] o_pos_error,
  output reg o_loop_enable,
  output reg [31:0] o_counts_per_rev
);

  // Gear parameters as software wrote them; unused until a restart
  reg [15:0] g16_num_r, g16_den_r, g32_nh_r, g32_nl_r, g32_dh_r, g32_dl_r;
  // Control fields: width select, clear mode, servo enable, zero clamp
  reg width32_r;
  reg [1:0] mode_r;
  reg servo_on_r;
  reg zclamp_r;
  // Ratio in use and the fraction carried between reference pulses
  reg [31:0] num_r, den_r;
  reg [31:0] rem_r;
  // Error counter, two's complement
  reg [ERR_W-1:0] err_r;
  // One-cycle apply strobe after reset or a restart write
  reg cal_busy_r;
  // Previous servo enable and overtravel, for edge detection
  reg servo_on_d_r, ot_d_r;
  // Synchronisers
  reg [1:0] pul_s_r, dir_s_r, clr_s_r;
  reg pul_d_r;

  // Combine high and low parts of a 32-bit gear value
  function [31:0] combine;
    input [15:0] hi;
    input [15:0] lo;
    begin
      combine = ({16'h0000, hi} * `GEAR_PART_SCALE) + {16'h0000, lo};
    end
  endfunction

  // Write data merge under byte enables
  function [15:0] merge16;
    input [15:0] old;
    input [31:0] d;
    input [3:0] sel;
    begin
      merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
    end
  endfunction

  // Add or take away one scaled reference step; forward adds to the error
  function [ERR_W-1:0] ref_apply;
    input [ERR_W-1:0] cur;
    input [ERR_W-1:0] stp;
    input fwd;
    begin
      if (fwd)
        ref_apply = cur + stp;
      else
        ref_apply = cur - stp;
    end
  endfunction

  // One encoder count against the error; forward feedback takes one away
  function [ERR_W-1:0] fb_apply;
    input [ERR_W-1:0] cur;
    input fwd;
    begin
      if (fwd)
        fb_apply = cur - {{(ERR_W-1){1'b0}}, 1'b1};
      else
        fb_apply = cur + {{(ERR_W-1){1'b0}}, 1'b1};
    end
  endfunction

  // Zero-extend a 16-bit register to the bus width; upper bits read zero
  function [31:0] zx16;
    input [15:0] v;
    begin
      zx16 = {16'h0000, v};
    end
  endfunction

  // Bus decode: a request is taken while ack is low, so each request gets
  // one ack, which drops in the cycle after it was given
  wire wb_req = i_wb_cyc & i_wb_stb & ~o_wb_ack;
  // A write lands on the edge at which the master samples ack high, while
  // address, data and byte enables still stand
  wire wb_wr = i_wb_cyc & i_wb_stb & i_wb_we & o_wb_ack;

  // Input synchronisers for host pins
  // Only the second flop of each chain feeds logic; the first may be
  // metastable. The clear chain resets released, so reset is no clear.
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      pul_s_r <= 2'h0;
      dir_s_r <= 2'h0;
      clr_s_r <= 2'h3;
      pul_d_r <= 1'b0;
    end else begin
      pul_s_r <= {pul_s_r[0], i_ref_pulse};
      dir_s_r <= {dir_s_r[0], i_ref_dir};
      clr_s_r <= {clr_s_r[0], i_error_clear_n};
      pul_d_r <= pul_s_r[1];
    end
  end

  wire ref_edge = pul_s_r[1] & ~pul_d_r;
  wire clr_active = ~clr_s_r[1];

  // Auto clear decision from the mode; events are rising edges of off/overtravel
  // Overtravel acts on its rising edge only, so a held limit switch does not
  // keep wiping the error after the axis has been backed off it
  wire servo_off_ev = servo_on_d_r & ~servo_on_r;
  wire ot_ev = i_overtravel & ~ot_d_r;
  reg auto_clr;
  always @* begin
    case (mode_r)
      `MODE_OFF_ONLY: auto_clr = servo_off_ev;
      `MODE_NEVER: auto_clr = 1'b0;
      `MODE_OFF_OT: auto_clr = servo_off_ev | (ot_ev & ~zclamp_r);
      // Unused encoding 3 never clears
      default: auto_clr = 1'b0;
    endcase
  end

  // Wishbone register writes; gear ratio latched only on reset or restart
  // Byte lanes 1:0 reach the 16-bit registers; lanes 3:2 are ignored.
  // A restart write raises cal_busy_r for one cycle; reset leaves it set.
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      g16_num_r <= `RST_G16;
      g16_den_r <= `RST_G16;
      g32_nh_r <= `RST_G32_HI;
      g32_nl_r <= `RST_G32_LO;
      g32_dh_r <= `RST_G32_HI;
      g32_dl_r <= `RST_G32_LO;
      width32_r <= 1'b0;
      mode_r <= `MODE_OFF_ONLY;
      servo_on_r <= 1'b0;
      zclamp_r <= 1'b0;
      cal_busy_r <= 1'b1;
    end else begin
      cal_busy_r <= 1'b0;
      if (wb_wr) begin
        case (i_wb_adr)
          `ADR_G16_NUM: g16_num_r <= merge16(g16_num_r, i_wb_dat, i_wb_sel);
          `ADR_G16_DEN: g16_den_r <= merge16(g16_den_r, i_wb_dat, i_wb_sel);
          `ADR_G32_NUM_HI: g32_nh_r <= merge16(g32_nh_r, i_wb_dat, i_wb_sel);
          `ADR_G32_NUM_LO: g32_nl_r <= merge16(g32_nl_r, i_wb_dat, i_wb_sel);
          `ADR_G32_DEN_HI: g32_dh_r <= merge16(g32_dh_r, i_wb_dat, i_wb_sel);
          `ADR_G32_DEN_LO: g32_dl_r <= merge16(g32_dl_r, i_wb_dat, i_wb_sel);
          `ADR_CTRL: begin
            if (i_wb_sel[0]) begin
              width32_r <= i_wb_dat[`CTRL_WIDTH_BIT];
              mode_r <= i_wb_dat[`CTRL_MODE_HI:`CTRL_MODE_LO];
              servo_on_r <= i_wb_dat[`CTRL_SERVO_BIT];
              zclamp_r <= i_wb_dat[`CTRL_ZCLAMP_BIT];
              // Restart request reloads the applied ratio next cycle
              cal_busy_r <= i_wb_dat[`CTRL_RESTART_BIT];
            end
          end
          default: ;
        endcase
      end
    end
  end

  // Applied ratio: captured only at reset or restart, so edits do not disturb motion
  // Out-of-range ratios are not refused here; keeping them sane is the host's duty
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      num_r <= 32'h00000001;
      den_r <= 32'h00000001;
    end else if (cal_busy_r) begin
      if (width32_r) begin
        num_r <= combine(g32_nh_r, g32_nl_r);
        den_r <= combine(g32_dh_r, g32_dl_r);
      end else begin
        num_r <= zx16(g16_num_r);
        den_r <= zx16(g16_den_r);
      end
    end
  end

  // Fraction step: per pulse add num, emit whole counts while rem >= den.
  // Ratio up to 100 means up to 100 counts per pulse; handled by division below.
  // The divider is combinational and deep: the 50 ns period covers it, but a
  // faster clock would want a serial divider and a busy flag instead.
  // A zero denominator would divide by zero, so it counts as one.
  wire [31:0] den_safe = (den_r == 32'h0) ? 32'h00000001 : den_r;
  wire [32:0] acc = {1'b0, rem_r} + {1'b0, num_r};
  wire [32:0] whole = acc / {1'b0, den_safe};
  wire [32:0] frac = acc % {1'b0, den_safe};
  wire [ERR_W-1:0] step = whole[ERR_W-1:0];

  // Error counter with clear priority and remainder carry
  // Clear pin, automatic clear and restart win over any count arriving in
  // the same cycle; the remainder goes with them, so a new move starts clean
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      err_r <= {ERR_W{1'b0}};
      rem_r <= 32'h0;
      servo_on_d_r <= 1'b0;
      ot_d_r <= 1'b0;
    end else begin
      servo_on_d_r <= servo_on_r;
      ot_d_r <= i_overtravel;
      if (clr_active || auto_clr || cal_busy_r) begin
        err_r <= {ERR_W{1'b0}};
        rem_r <= 32'h0;
      end else begin
        // Sign of the reference step follows the direction pin
        case ({ref_edge, i_fb_pulse})
          2'b10: err_r <= ref_apply(err_r, step, dir_s_r[1]);
          2'b01: err_r <= fb_apply(err_r, i_fb_dir);
          // Both in one cycle: reference step first, then the encoder count
          2'b11: err_r <= fb_apply(ref_apply(err_r, step, dir_s_r[1]), i_fb_dir);
          default: err_r <= err_r;
        endcase
        if (ref_edge)
          rem_r <= frac[31:0];
      end
    end
  end

  // Outputs and register read data
  // Every output leaves from a flop, so the far side sees no decode glitches.
  // Read data is zero outside an ack, which keeps a shared bus OR-able.
  // Feedback direction is used as is: it already runs on this clock.
  always @(posedge i_core_clk) begin
    if (i_rst) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= 32'h0;
      o_pos_error <= {ERR_W{1'b0}};
      o_loop_enable <= 1'b0;
      o_counts_per_rev <= 32'h0;
    end else begin
      o_wb_ack <= wb_req;
      o_pos_error <= err_r;
      o_loop_enable <= servo_on_r & ~clr_active;
      o_counts_per_rev <= ENC_LINES * `QUAD_MULT;
      o_wb_dat <= 32'h0;
      if (wb_req && !i_wb_we) begin
        case (i_wb_adr)
          `ADR_G16_NUM: o_wb_dat <= zx16(g16_num_r);
          `ADR_G16_DEN: o_wb_dat <= zx16(g16_den_r);
          `ADR_G32_NUM_HI: o_wb_dat <= zx16(g32_nh_r);
          `ADR_G32_NUM_LO: o_wb_dat <= zx16(g32_nl_r);
          `ADR_G32_DEN_HI: o_wb_dat <= zx16(g32_dh_r);
          `ADR_G32_DEN_LO: o_wb_dat <= zx16(g32_dl_r);
          // Control reads back as written, without the restart bit
          `ADR_CTRL: o_wb_dat <= {27'h0, zclamp_r, servo_on_r, mode_r, width32_r};
          // Status: bit 0 servo on, bit 1 clear pin released, bit 2 overtravel
          `ADR_STATUS: o_wb_dat <= {29'h0, i_overtravel, ~clr_active, servo_on_r};
          `ADR_ERROR: o_wb_dat <= err_r;
          `ADR_APPLIED_NUM: o_wb_dat <= num_r;
          `ADR_APPLIED_DEN: o_wb_dat <= den_r;
          default: o_wb_dat <= 32'h0;
        endcase
      end
    end
  end

endmodule // position_error_clear_and_gear

//--- hw/gear_defines.vh
// What this block does
// - Clear input low forces error counter zero
// - While clearing, position loop correction is suspended
// - Mode one: clear at servo off only
// - Mode two: never clear automatically
// - Mode three: clear on off/overtravel, not clamp
// - Width select picks 16-bit or 32-bit gear
// - 16-bit ratio num/den, 1..65535, default 1, restart
// - 32-bit parts combine as high*10000 plus low
// - Parts 1..9999; high default 0, low 1
// - One revolution is four times encoder lines
// - Each reference pulse advances command by ratio
`ifndef GEAR_DEFINES_VH
`define GEAR_DEFINES_VH
// Register byte addresses
`define ADR_G16_NUM 8'h00
`define ADR_G16_DEN 8'h04
`define ADR_G32_NUM_HI 8'h08
`define ADR_G32_NUM_LO 8'h0C
`define ADR_G32_DEN_HI 8'h10
`define ADR_G32_DEN_LO 8'h14
`define ADR_CTRL 8'h18
`define ADR_STATUS 8'h1C
`define ADR_ERROR 8'h20
`define ADR_APPLIED_NUM 8'h24
`define ADR_APPLIED_DEN 8'h28
// Reset values
`define RST_G16 16'h0001
`define RST_G32_HI 16'h0000
`define RST_G32_LO 16'h0001
// Control fields
`define CTRL_WIDTH_BIT 0
`define CTRL_MODE_LO 1
`define CTRL_MODE_HI 2
`define CTRL_SERVO_BIT 3
`define CTRL_ZCLAMP_BIT 4
`define CTRL_RESTART_BIT 5
// Auto clear modes
`define MODE_OFF_ONLY 2'h0
`define MODE_NEVER 2'h1
`define MODE_OFF_OT 2'h2
// Part scale of the 32-bit form
`define GEAR_PART_SCALE 32'h00002710
// Counts per revolution multiplier
`define QUAD_MULT 4
`endif

//--- verif/pecg_props.sv
`timescale 1ns/1ns
// Port-level checks of bus timing, clear pin and error counter
module pecg_props #(
  parameter ERR_W = 32,
  parameter ENC_LINES = 32768
) (
  // Clock, reset and inputs
  input wire i_core_clk,
  input wire i_rst,
  input wire i_wb_cyc,
  input wire i_wb_stb,
  input wire i_ref_pulse,
  input wire i_error_clear_n,
  input wire i_overtravel,
  input wire i_fb_pulse,
  // Outputs
  input wire [31:0] o_wb_dat,
  input wire o_wb_ack,
  input wire [ERR_W-1:0] o_pos_error,
  input wire o_loop_enable,
  input wire [31:0] o_counts_per_rev
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  ack_one_cycle_a: assert property (o_wb_ack |=> !o_wb_ack)
    else $error("ack longer than one cycle");
  ack_answer_a: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
    else $error("request not answered next cycle");
  ack_cause_a: assert property (o_wb_ack |-> $past(i_wb_cyc) && $past(i_wb_stb))
    else $error("ack without request");
  dat_idle_a: assert property (!o_wb_ack |-> o_wb_dat == 32'h0)
    else $error("read data outside ack");
  clear_zero_a: assert property (!i_error_clear_n [*5] |-> o_pos_error == '0)
    else $error("error not zero while clearing");
  clear_loop_a: assert property (!i_error_clear_n [*5] |-> !o_loop_enable)
    else $error("loop active while clearing");
  rev_count_a: assert property (!i_rst [*3] |-> o_counts_per_rev == ENC_LINES * 4)
    else $error("counts per revolution wrong");
  // Pipeline of the pin synchroniser is drained after six quiet cycles
  idle_error_a: assert property ((!i_fb_pulse && !i_overtravel && i_error_clear_n
    && !i_wb_cyc && $stable(i_ref_pulse)) [*6] |=> $stable(o_pos_error))
    else $error("error moved with no cause");
  cover property (!i_error_clear_n [*5]);
  cover property ($rose(i_overtravel));
  cover property (o_wb_ack && o_wb_dat != 32'h0);
endmodule // pecg_props
bind position_error_clear_and_gear pecg_props #(.ERR_W(ERR_W), .ENC_LINES(ENC_LINES)) u_props (
  .i_core_clk, .i_rst, .i_wb_cyc, .i_wb_stb, .i_ref_pulse, .i_error_clear_n, .i_overtravel,
  .i_fb_pulse, .o_wb_dat, .o_wb_ack, .o_pos_error, .o_loop_enable, .o_counts_per_rev);

//--- verif/host_model.sv
`timescale 1ns/1ns
// Motion controller: reference pulses and clear line, moved just after the clock
module host_model (
  // Clock
  input wire i_core_clk,
  // Pins towards the drive
  output logic o_ref_pulse,
  output logic o_ref_dir,
  output logic o_error_clear_n
);
  // Idle pin levels
  initial begin
    o_ref_pulse = 1'b0;
    o_ref_dir = 1'b1;
    o_error_clear_n = 1'b1;
  end
  // Four cycles high and low, so the pin synchroniser sees every edge
  task send(input int n, input logic dir);
    @(posedge i_core_clk) o_ref_dir <= dir;
    repeat (2) @(posedge i_core_clk);
    repeat (n) begin
      o_ref_pulse <= 1'b1;
      repeat (4) @(posedge i_core_clk);
      o_ref_pulse <= 1'b0;
      repeat (4) @(posedge i_core_clk);
    end
  endtask
  task set_clear_n(input logic v);
    @(posedge i_core_clk) o_error_clear_n <= v;
  endtask
endmodule // host_model

//--- verif/position_error_clear_and_gear_tb.sv
`timescale 1ns/1ns
`include "gear_defines.vh"
module position_error_clear_and_gear_tb;
  logic clk, rst, cyc, stb, we, ot, fb, fbd;
  logic [7:0] adr;
  logic [31:0] wdat, q, e;
  wire ref_p, ref_d, clr_n, ack, loop_en;
  wire [31:0] rdat, cpr, perr;
  int n_errors = 0, checks_done = 0, cycles = 0, md, zc;
  logic [31:0] rst_tab [6] = '{32'h1, 32'h1, 32'h0, 32'h1, 32'h0, 32'h1};
  position_error_clear_and_gear DUT (.i_core_clk(clk), .i_rst(rst), .i_wb_cyc(cyc),
    .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(4'hF), .i_wb_dat(wdat),
    .o_wb_dat(rdat), .o_wb_ack(ack), .i_ref_pulse(ref_p), .i_ref_dir(ref_d),
    .i_error_clear_n(clr_n), .i_overtravel(ot), .i_fb_pulse(fb), .i_fb_dir(fbd),
    .o_pos_error(perr), .o_loop_enable(loop_en), .o_counts_per_rev(cpr));
  host_model host (.i_core_clk(clk), .o_ref_pulse(ref_p), .o_ref_dir(ref_d),
    .o_error_clear_n(clr_n));
  // Clock, 50 ns period
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // Watchdog well above the few hundred cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      final_report();
    end
  end
  task final_report;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Classic cycle: request held until ack is sampled high
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0; stb <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  task idle(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Main sequence
  initial begin
    rst = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; wdat = 32'h0; ot = 1'b0; fb = 1'b0;
    fbd = 1'b1;
    idle(3);
    rst <= 1'b0;
    for (int i = 0; i < 6; i++) rd(8'(4 * i), rst_tab[i]);
    rd(`ADR_APPLIED_NUM, 32'h1);
    rd(8'h30, 32'h0);
    chk(cpr, 32'h00020000);
    // Ratio 3/2 sits inside the range the host must respect
    wb(1'b1, `ADR_G16_NUM, 32'h3);
    wb(1'b1, `ADR_G16_DEN, 32'h2);
    wb(1'b1, `ADR_CTRL, 32'h28);
    rd(`ADR_APPLIED_DEN, 32'h2);
    host.send(5, 1'b1);
    idle(8);
    chk(perr, 32'h7);
    repeat (3) begin
      @(posedge clk) fb <= 1'b1;
      @(posedge clk) fb <= 1'b0;
    end
    idle(4);
    chk(perr, 32'h4);
    // One reverse encoder count adds to the error
    @(posedge clk);
    fb <= 1'b1;
    fbd <= 1'b0;
    @(posedge clk);
    fb <= 1'b0;
    fbd <= 1'b1;
    idle(4);
    chk(perr, 32'h5);
    host.set_clear_n(1'b0);
    idle(6);
    chk(perr, 32'h0);
    chk(32'(loop_en), 32'h0);
    host.set_clear_n(1'b1);
    idle(6);
    chk(32'(loop_en), 32'h1);
    // Each mode: overtravel first, then servo off; last pass uses zero clamp
    for (int m = 0; m < 4; m++) begin
      md = (m > 2) ? 2 : m;
      zc = (m == 3);
      wb(1'b1, `ADR_CTRL, 32'(32'h28 | (md << 1) | (zc << 4)));
      host.send(2, 1'b1);
      e = 32'h3;
      @(posedge clk) ot <= 1'b1;
      idle(6);
      ot <= 1'b0;
      idle(4);
      if (md == 2 && zc == 0) e = 32'h0;
      chk(perr, e);
      wb(1'b1, `ADR_CTRL, 32'((md << 1) | (zc << 4)));
      idle(4);
      if (md != 1) e = 32'h0;
      chk(perr, e);
    end
    wb(1'b1, `ADR_G32_NUM_HI, 32'h1);
    wb(1'b1, `ADR_G32_NUM_LO, 32'h2);
    wb(1'b1, `ADR_G32_DEN_HI, 32'h1);
    wb(1'b1, `ADR_G32_DEN_LO, 32'h1);
    wb(1'b1, `ADR_CTRL, 32'h29);
    rd(`ADR_APPLIED_NUM, 32'h00002712);
    rd(`ADR_APPLIED_DEN, 32'h00002711);
    host.send(1, 1'b1);
    idle(8);
    chk(perr, 32'h1);
    // Reverse pulse: carried remainder 1 plus 10002 over 10001 is one count
    host.send(1, 1'b0);
    idle(8);
    chk(perr, 32'h0);
    final_report();
  end
endmodule // position_error_clear_and_gear_tb
